//--- core/power_crystal_startup_options_bank.sv
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Bit 4 of converter options reports boost pass-through support.
// - Bit 3 enables boost for low-power detect, never ultra-low-power detect.
// - Regulator options bit 1 enables transmit regulator overcurrent protection.
// - Regulator options bit 0 enables the transmit regulator output.
// - Amplifier supply code means 1.5 V plus 0.1 V steps, max 0x2a.
// - Three separate maximum supply codes: general reader, payment reader, card.
// - Boost code means 3.1 V plus 0.1 V steps, 0x00 to 0x1d valid.
// - Recalibration starts after a wake-up seen while the crystal sequence is idle, only when crystal bit 0 set.
// - Crystal ready timeout is code times 128 us.
// - Crystal start wait is code times 128 us times 50 loops.
// - Regulator output is held off for off-wait code times 128 us after boost off, then regulator_off pulses.
// - Reserved bytes and reserved bits have no function.
module power_crystal_startup_options_bank (
  input wire logic clk_sys, // System clock
  input wire logic nrst, // Async reset, active low
  input wire logic [31:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [31:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read valid
  input wire logic s_axi_rready, // Read ready
  input wire logic [1:0] op_mode, // Active mode, same clock
  input wire logic wake_up, // Wake-up pin
  input wire logic boost_shutdown, // Boost shutdown pin, dynamic power ctrl
  output var pwr_cfg_pkg::analog_ctrl_t analog_ctrl, // Decoded analog controls
  output var pwr_cfg_pkg::seq_events_t seq_events // Sequencer pulses
);
  import pwr_cfg_pkg::*;

  typedef enum {
    XS_IDLE,
    XS_START_WAIT,
    XS_READY_WAIT
  } xtal_state_t;

  logic [1:0] rst_sync_r;
  logic rst_n;
  logic [7:0] conv_r, amp_r, max_gen_r, max_card_r, boost_r;
  logic [7:0] xcfg_r, xtmo_r, max_pay_r, start_wait_r, off_wait_r;
  logic [31:0] regw_r;
  logic power_ctrl_en_r, xtal_ready_r;
  logic [2:0] wake_sync_r, boff_sync_r;
  logic wake_prev_r, boff_prev_r;
  logic wake_evt, boff_evt;
  logic [15:0] tick_cnt_r;
  logic tick;
  logic [13:0] loop_cnt_r;
  logic [7:0] off_cnt_r;
  logic off_busy_r;
  xtal_state_t xs_r;
  logic aw_held_r, w_held_r;
  logic [31:0] awaddr_r, wdata_r;
  logic [3:0] wstrb_r;
  logic [7:0] mode_max;

  // Saturate a code at its own ceiling
  function automatic logic [7:0] sat(input logic [7:0] c,
                                     input logic [7:0] m);
    sat = (c > m) ? m : c;
  endfunction

  function automatic logic addr_ok(input logic [31:0] a);
    addr_ok = (a[1:0] == 2'b00) && (a[31:14] == 18'h0);
  endfunction

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // Pins: three stages, change accepted when stages two and three agree
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wake_sync_r <= 3'b000;
      boff_sync_r <= 3'b000;
      wake_prev_r <= 1'b0;
      boff_prev_r <= 1'b0;
    end else begin
      wake_sync_r <= {wake_sync_r[1:0], wake_up};
      boff_sync_r <= {boff_sync_r[1:0], boost_shutdown};
      if (wake_sync_r[2] == wake_sync_r[1]) begin
        wake_prev_r <= wake_sync_r[2];
      end
      if (boff_sync_r[2] == boff_sync_r[1]) begin
        boff_prev_r <= boff_sync_r[2];
      end
    end
  end
  assign wake_evt = (wake_sync_r[2] == wake_sync_r[1]) && wake_sync_r[2] &&
                    !wake_prev_r;
  assign boff_evt = (boff_sync_r[2] == boff_sync_r[1]) && boff_sync_r[2] &&
                    !boff_prev_r;

  // AXI write path: address and data taken in either order
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 32'h0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= (s_axi_awvalid && s_axi_awready) ? 1'b0 :
                       (!aw_held_r && !s_axi_bvalid);
      s_axi_wready <= (s_axi_wvalid && s_axi_wready) ? 1'b0 :
                      (!w_held_r && !s_axi_bvalid);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (aw_held_r && w_held_r && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_ok(awaddr_r) ? 2'b00 : 2'b10;
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  logic do_wr;
  logic [11:0] widx;
  assign do_wr = aw_held_r && w_held_r && !s_axi_bvalid &&
                 addr_ok(awaddr_r);
  assign widx = awaddr_r[13:2];

  // Byte registers keep all eight bits; reserved bits simply drive nothing
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      conv_r <= RST_BYTE;
      regw_r <= RST_WORD;
      amp_r <= RST_BYTE;
      max_gen_r <= RST_BYTE;
      max_card_r <= RST_BYTE;
      boost_r <= RST_BYTE;
      xcfg_r <= RST_BYTE;
      xtmo_r <= RST_BYTE;
      max_pay_r <= RST_BYTE;
      start_wait_r <= RST_START_WAIT;
      off_wait_r <= RST_OFF_WAIT;
      power_ctrl_en_r <= 1'b0;
    end else if (do_wr) begin
      if (wstrb_r[0]) begin
        case (widx)
          IDX_CONVERTER_OPTIONS: conv_r <= wdata_r[7:0];
          IDX_AMP_SUPPLY_LEVEL: amp_r <= wdata_r[7:0];
          IDX_AMP_MAX_READER_GENERAL: max_gen_r <= wdata_r[7:0];
          IDX_AMP_MAX_CARD: max_card_r <= wdata_r[7:0];
          IDX_BOOST_OUTPUT_LEVEL: boost_r <= wdata_r[7:0];
          IDX_CRYSTAL_STARTUP_OPTIONS: xcfg_r <= wdata_r[7:0];
          IDX_CRYSTAL_READY_TIMEOUT: xtmo_r <= wdata_r[7:0];
          IDX_AMP_MAX_READER_PAYMENT: max_pay_r <= wdata_r[7:0];
          IDX_CRYSTAL_START_WAIT: start_wait_r <= wdata_r[7:0];
          IDX_REGULATOR_OFF_WAIT: off_wait_r <= wdata_r[7:0];
          IDX_SEQ_CONTROL: power_ctrl_en_r <= wdata_r[0];
          default: ;
        endcase
      end
      if (widx == IDX_TX_REGULATOR_OPTIONS) begin
        for (int b = 0; b < 4; b++) begin
          if (wstrb_r[b]) begin
            regw_r[b*8 +: 8] <= wdata_r[b*8 +: 8];
          end
        end
      end
    end
  end

  function automatic logic [31:0] rd_mux(input logic [11:0] i);
    case (i)
      IDX_CONVERTER_OPTIONS: rd_mux = {24'h0, conv_r};
      IDX_TX_REGULATOR_OPTIONS: rd_mux = regw_r;
      IDX_AMP_SUPPLY_LEVEL: rd_mux = {24'h0, amp_r};
      IDX_AMP_MAX_READER_GENERAL: rd_mux = {24'h0, max_gen_r};
      IDX_AMP_MAX_CARD: rd_mux = {24'h0, max_card_r};
      IDX_BOOST_OUTPUT_LEVEL: rd_mux = {24'h0, boost_r};
      IDX_CRYSTAL_STARTUP_OPTIONS: rd_mux = {24'h0, xcfg_r};
      IDX_CRYSTAL_READY_TIMEOUT: rd_mux = {24'h0, xtmo_r};
      IDX_AMP_MAX_READER_PAYMENT: rd_mux = {24'h0, max_pay_r};
      IDX_CRYSTAL_START_WAIT: rd_mux = {24'h0, start_wait_r};
      IDX_REGULATOR_OFF_WAIT: rd_mux = {24'h0, off_wait_r};
      IDX_SEQ_CONTROL: rd_mux = {31'h0, power_ctrl_en_r};
      IDX_SEQ_STATUS: rd_mux = {28'h0, off_busy_r, xtal_ready_r,
                                (xs_r == XS_READY_WAIT),
                                (xs_r == XS_START_WAIT)};
      default: rd_mux = 32'h0;
    endcase
  endfunction

  // AXI read path, one cycle to answer
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'b00;
      s_axi_arready <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= addr_ok(s_axi_araddr) ?
                     rd_mux(s_axi_araddr[13:2]) : 32'h0;
      s_axi_rresp <= addr_ok(s_axi_araddr) ? 2'b00 : 2'b10;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid;
    end
  end

  // Mode ceiling, itself saturated at the encoding's ceiling
  always_comb begin
    case (op_mode)
      MODE_READER_PAYMENT: mode_max = sat(max_pay_r, AMP_CODE_MAX);
      MODE_CARD: mode_max = sat(max_card_r, AMP_CODE_MAX);
      default: mode_max = sat(max_gen_r, AMP_CODE_MAX);
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      analog_ctrl <= '0;
    end else begin
      analog_ctrl.pass_through_supported <= conv_r[BIT_PASS_THROUGH];
      analog_ctrl.detect_uses_boost <= conv_r[BIT_DETECT_BOOST];
      analog_ctrl.overcurrent_en <= regw_r[BIT_OVERCURRENT];
      analog_ctrl.reg_enable <= regw_r[BIT_REG_ENABLE] && !off_busy_r;
      analog_ctrl.amp_code <= sat(amp_r, mode_max);
      analog_ctrl.boost_code <= sat(boost_r, BOOST_CODE_MAX);
    end
  end

  // 128 us tick, free running
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_r <= 16'h0;
    end else if (tick) begin
      tick_cnt_r <= 16'h0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 16'h1;
    end
  end
  assign tick = (tick_cnt_r == 16'(TICK_CYCLES - 1));

  // Crystal start sequence after a wake-up seen while idle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      xs_r <= XS_IDLE;
      loop_cnt_r <= 14'h0;
      xtal_ready_r <= 1'b0;
      seq_events <= '0;
    end else begin
      seq_events.recal_start <= 1'b0;
      seq_events.crystal_start <= 1'b0;
      seq_events.crystal_timeout <= 1'b0;
      seq_events.regulator_off <= 1'b0;
      if (off_busy_r && tick && off_cnt_r <= 8'h1) begin
        seq_events.regulator_off <= 1'b1;
      end
      case (xs_r)
        XS_IDLE: begin
          if (wake_evt) begin
            seq_events.recal_start <= xcfg_r[BIT_RECAL];
            loop_cnt_r <= 14'(start_wait_r * START_LOOPS);
            xtal_ready_r <= 1'b0;
            xs_r <= XS_START_WAIT;
          end
        end
        XS_START_WAIT: begin
          if (loop_cnt_r == 14'h0) begin
            seq_events.crystal_start <= 1'b1;
            loop_cnt_r <= {6'h0, xtmo_r};
            xs_r <= XS_READY_WAIT;
          end else if (tick) begin
            loop_cnt_r <= loop_cnt_r - 14'h1;
          end
        end
        XS_READY_WAIT: begin
          // Timeout pulses crystal_timeout, sets crystal ready and ends the sequence
          if (loop_cnt_r == 14'h0) begin
            seq_events.crystal_timeout <= 1'b1;
            xtal_ready_r <= 1'b1;
            xs_r <= XS_IDLE;
          end else if (tick) begin
            loop_cnt_r <= loop_cnt_r - 14'h1;
          end
        end
        default: xs_r <= XS_IDLE;
      endcase
    end
  end

  // Regulator switch-off wait after boost shutdown
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      off_busy_r <= 1'b0;
      off_cnt_r <= 8'h0;
    end else if (boff_evt && power_ctrl_en_r && !off_busy_r) begin
      off_busy_r <= 1'b1;
      off_cnt_r <= off_wait_r;
    end else if (off_busy_r && tick) begin
      if (off_cnt_r <= 8'h1) begin
        off_busy_r <= 1'b0;
      end
      off_cnt_r <= off_cnt_r - 8'h1;
    end
  end

  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  a_amp_clamped: assert property (
    analog_ctrl.amp_code <= AMP_CODE_MAX)
    else $error("amp code above ceiling");
  a_boost_clamped: assert property (
    analog_ctrl.boost_code <= BOOST_CODE_MAX)
    else $error("boost code above ceiling");
  a_mode_clamp: assert property (
    ##1 analog_ctrl.amp_code <= $past(mode_max))
    else $error("amp code above mode maximum");
  a_pass_through: assert property (
    ##1 analog_ctrl.pass_through_supported == $past(conv_r[4]))
    else $error("pass-through flag wrong");
  a_detect_boost: assert property (
    $rose(analog_ctrl.detect_uses_boost) |-> $past(conv_r[3]))
    else $error("detect boost without config");
  a_ocp_follow: assert property (
    $changed(regw_r[1]) |=> analog_ctrl.overcurrent_en == $past(regw_r[1]))
    else $error("overcurrent enable lags");
  a_reg_off: assert property (
    !regw_r[0] |=> !analog_ctrl.reg_enable)
    else $error("regulator on while disabled");
  a_recal_gate: assert property (
    seq_events.recal_start |-> $past(xcfg_r[0]))
    else $error("recal without enable");
  a_start_after: assert property (
    seq_events.crystal_start |-> $past(xs_r) == XS_START_WAIT)
    else $error("start outside wait");
  a_off_wait: assert property (
    seq_events.regulator_off |-> $past(off_busy_r))
    else $error("regulator off without wait");
  c_wake: cover property (seq_events.crystal_start);
  c_timeout: cover property (seq_events.crystal_timeout);
  c_off: cover property (seq_events.regulator_off);
endmodule
`default_nettype wire

//--- pkg/pwr_cfg_pkg.sv
package pwr_cfg_pkg;
  // Register indices; the byte address is four times the index
  localparam logic [11:0] IDX_CONVERTER_OPTIONS = 12'h001;
  localparam logic [11:0] IDX_TX_REGULATOR_OPTIONS = 12'h002;
  localparam logic [11:0] IDX_AMP_SUPPLY_LEVEL = 12'h006;
  localparam logic [11:0] IDX_AMP_MAX_READER_GENERAL = 12'h007;
  localparam logic [11:0] IDX_AMP_MAX_CARD = 12'h008;
  localparam logic [11:0] IDX_BOOST_OUTPUT_LEVEL = 12'h009;
  localparam logic [11:0] IDX_CRYSTAL_STARTUP_OPTIONS = 12'h00f;
  localparam logic [11:0] IDX_CRYSTAL_READY_TIMEOUT = 12'h010;
  localparam logic [11:0] IDX_AMP_MAX_READER_PAYMENT = 12'h6a6;
  localparam logic [11:0] IDX_CRYSTAL_START_WAIT = 12'h6b8;
  localparam logic [11:0] IDX_REGULATOR_OFF_WAIT = 12'h6b9;
  localparam logic [11:0] IDX_RESERVED_A = 12'h6ba;
  localparam logic [11:0] IDX_RESERVED_B = 12'h6bb;
  localparam logic [11:0] IDX_SEQ_CONTROL = 12'h700;
  localparam logic [11:0] IDX_SEQ_STATUS = 12'h701;

  localparam int BIT_PASS_THROUGH = 4;
  localparam int BIT_DETECT_BOOST = 3;
  localparam int BIT_OVERCURRENT = 1;
  localparam int BIT_REG_ENABLE = 0;
  localparam int BIT_RECAL = 0;

  localparam logic [7:0] AMP_CODE_MAX = 8'h2a;
  localparam logic [7:0] BOOST_CODE_MAX = 8'h1d;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [7:0] RST_START_WAIT = 8'h01;
  localparam logic [7:0] RST_OFF_WAIT = 8'h01;

  localparam int CLK_MHZ = 200;
  localparam int TICK_US = 128;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
  localparam int START_LOOPS = 50;

  typedef enum logic [1:0] {
    MODE_READER_GENERAL,
    MODE_READER_PAYMENT,
    MODE_CARD
  } op_mode_t;

  typedef struct packed {
    logic pass_through_supported;
    logic detect_uses_boost;
    logic reg_enable;
    logic overcurrent_en;
    logic [7:0] amp_code;
    logic [7:0] boost_code;
  } analog_ctrl_t;

  typedef struct packed {
    logic recal_start;
    logic crystal_start;
    logic crystal_timeout;
    logic regulator_off;
  } seq_events_t;
endpackage

//--- test/test_power_crystal_startup_options_bank.sv
`timescale 1ns/1ps
`default_nettype none
module test_power_crystal_startup_options_bank;
  import pwr_cfg_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [1:0] op_mode = 2'h0;
  logic wake_up = 0, boost_shutdown = 0;
  analog_ctrl_t actl;
  seq_events_t sev;
  int error_cnt = 0, total_checks = 0;
  logic [1:0] rsp;
  logic [31:0] rd;
  int n;
  logic [7:0] amp_exp [4] = '{8'h10, 8'h20, 8'h25, 8'h10};
  logic [7:0] bst_in [3] = '{8'h05, 8'h1d, 8'h1e};
  logic [7:0] bst_exp [3] = '{8'h05, 8'h1d, 8'h1d};

  always #2.5 clk_sys = ~clk_sys;

  power_crystal_startup_options_bank uut (.clk_sys(clk_sys), .nrst(nrst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .op_mode(op_mode), .wake_up(wake_up),
    .boost_shutdown(boost_shutdown), .analog_ctrl(actl),
    .seq_events(sev));

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr_a(input logic [31:0] a, input logic [31:0] d,
                      output logic [1:0] r);
    bit aw_done, w_done;
    int k;
    aw_done = 0;
    w_done = 0;
    k = 0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge clk_sys);
      k++;
      if (!aw_done && s_axi_awready === 1'b1) begin
        aw_done = 1;
        s_axi_awvalid <= 0;
      end
      if (!w_done && s_axi_wready === 1'b1) begin
        w_done = 1;
        s_axi_wvalid <= 0;
      end
    end while (!(aw_done && w_done) && k < 500);
    while (s_axi_bvalid !== 1'b1 && k < 1000) begin
      @(posedge clk_sys);
      k++;
    end
    if (k >= 1000) chk("write handshake", 0, 1);
    r = s_axi_bresp;
    s_axi_bready <= 0;
  endtask

  task automatic rd_a(input logic [31:0] a, output logic [31:0] d,
                      output logic [1:0] r);
    int k;
    k = 0;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge clk_sys);
      k++;
    end while (s_axi_arready !== 1'b1 && k < 500);
    s_axi_arvalid <= 0;
    while (s_axi_rvalid !== 1'b1 && k < 1000) begin
      @(posedge clk_sys);
      k++;
    end
    if (k >= 1000) chk("read handshake", 0, 1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask

  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    wr_a({18'h0, idx, 2'b00}, d, rsp);
  endtask

  task automatic rd_chk(input string what, input logic [11:0] idx,
                        input logic [31:0] exp);
    rd_a({18'h0, idx, 2'b00}, rd, rsp);
    chk(what, rd, exp);
  endtask

  // Outputs are sampled on the falling edge, well clear of updates
  task automatic settle();
    repeat (4) @(negedge clk_sys);
  endtask

  task automatic wait_ev(input int b, input int lim, output int c);
    logic [3:0] v;
    c = 0;
    do begin
      @(negedge clk_sys);
      c++;
      v = sev;
    end while (v[b] !== 1'b1 && c < lim);
  endtask

  initial begin
    #(5ns * 90000);
    error_cnt++;
    end_of_test();
  end

  initial begin
    repeat (20) @(posedge clk_sys);
    nrst <= 1;
    repeat (3) @(posedge clk_sys);
    rd_chk("start_wait rst", IDX_CRYSTAL_START_WAIT, 32'h1);
    rd_chk("off_wait rst", IDX_REGULATOR_OFF_WAIT, 32'h1);
    rd_chk("conv rst", IDX_CONVERTER_OPTIONS, 32'h0);
    wr(IDX_CONVERTER_OPTIONS, 32'h0000_00ef);
    rd_chk("conv rmw", IDX_CONVERTER_OPTIONS, 32'h0000_00ef);
    settle();
    chk("pass_through", actl.pass_through_supported, 1'b0);
    chk("detect_boost", actl.detect_uses_boost, 1'b1);
    wr(IDX_CONVERTER_OPTIONS, 32'h0000_0010);
    settle();
    chk("pass_through", actl.pass_through_supported, 1'b1);
    chk("detect_boost", actl.detect_uses_boost, 1'b0);
    wr(IDX_TX_REGULATOR_OPTIONS, 32'hffff_fffe);
    rd_chk("reg opts", IDX_TX_REGULATOR_OPTIONS, 32'hffff_fffe);
    settle();
    chk("reg_enable", actl.reg_enable, 1'b0);
    chk("overcurrent", actl.overcurrent_en, 1'b1);
    wr(IDX_TX_REGULATOR_OPTIONS, 32'h0000_0001);
    settle();
    chk("reg_enable", actl.reg_enable, 1'b1);
    chk("overcurrent", actl.overcurrent_en, 1'b0);
    wr(IDX_AMP_MAX_READER_GENERAL, 32'h10);
    wr(IDX_AMP_MAX_READER_PAYMENT, 32'h20);
    wr(IDX_AMP_MAX_CARD, 32'h30);
    wr(IDX_AMP_SUPPLY_LEVEL, 32'h25);
    rd_chk("max payment", IDX_AMP_MAX_READER_PAYMENT, 32'h20);
    for (int m = 0; m < 4; m++) begin
      @(posedge clk_sys);
      op_mode <= m[1:0];
      settle();
      chk("amp per mode", actl.amp_code, amp_exp[m]);
    end
    wr(IDX_AMP_SUPPLY_LEVEL, 32'h40);
    op_mode <= 2'h2;
    settle();
    chk("amp saturate", actl.amp_code, AMP_CODE_MAX);
    wr(IDX_AMP_MAX_CARD, 32'h2a);
    wr(IDX_AMP_SUPPLY_LEVEL, 32'h2a);
    settle();
    chk("amp top code", actl.amp_code, 8'h2a);
    for (int i = 0; i < 3; i++) begin
      wr(IDX_BOOST_OUTPUT_LEVEL, {24'h0, bst_in[i]});
      settle();
      chk("boost code", actl.boost_code, bst_exp[i]);
    end
    wr(IDX_RESERVED_A, 32'h5a);
    rd_chk("reserved a", IDX_RESERVED_A, 32'h0);
    wr(IDX_RESERVED_B, 32'ha5);
    rd_chk("reserved b", IDX_RESERVED_B, 32'h0);
    rd_chk("unmapped", 12'h100, 32'h0);
    chk("unmapped resp", rsp, 2'b00);
    wr_a(32'h0000_0006, 32'h1, rsp);
    chk("misaligned resp", rsp, 2'b10);
    // Start wait of 0 keeps the run short; ready timeout is one tick
    wr(IDX_CRYSTAL_START_WAIT, 32'h0);
    wr(IDX_CRYSTAL_READY_TIMEOUT, 32'h1);
    wr(IDX_CRYSTAL_STARTUP_OPTIONS, 32'h1);
    wake_up <= 1;
    wait_ev(3, 40, n);
    chk("recal seen", n < 40, 1'b1);
    wait_ev(2, 40, n);
    chk("xtal start", n < 40, 1'b1);
    wait_ev(1, TICK_CYCLES + 40, n);
    chk("crystal_ready_timeout", n < TICK_CYCLES + 40, 1'b1);
    rd_chk("xtal status", IDX_SEQ_STATUS, 32'h4);
    wake_up <= 0;
    wr(IDX_CRYSTAL_STARTUP_OPTIONS, 32'h0);
    wr(IDX_CRYSTAL_READY_TIMEOUT, 32'h0);
    wake_up <= 1;
    wait_ev(3, 40, n);
    chk("no recal", n, 40);
    @(posedge clk_sys);
    wake_up <= 0;
    wr(IDX_SEQ_CONTROL, 32'h1);
    boost_shutdown <= 1;
    repeat (12) @(negedge clk_sys);
    chk("reg held off", actl.reg_enable, 1'b0);
    wait_ev(0, TICK_CYCLES + 40, n);
    chk("reg off pulse", n < TICK_CYCLES + 40, 1'b1);
    @(posedge clk_sys);
    boost_shutdown <= 0;
    end_of_test();
  end
endmodule
`default_nettype wire
